// ### common/phy_regs_pkg.sv
// Functional notes
// - Status bits 14 and 13 always read 1: 100BASE-TX full and half duplex.
// - Status bits 12 and 11 always read 1: 10BASE-T full and half duplex.
// - Status bits 15, 10 and 9 read 0: no T4, no T2 ability.
// - Status bit 8 reads 1 (extended status), though index 15 is unmapped and reads 0.
// - Status bit 5 reads 1 only once negotiation finished; resets to 0.
// - Status bit 4 latches high on a remote fault.
// - Status bit 1 latches high on a jabber condition.
// - Status bit 3 reports negotiation ability, bit 0 extended registers.
// - Identifier high word holds identifier bits 3 to 18, writable.
// - Identifier low word: identifier bits, model number, revision; writable.
// - Advertised next page bit is read/write, reset 0.
// - Advertised remote fault and asymmetric pause are read/write, reset 0.
// - Advertised pause is read/write, reset value from the pause strap.
// - Advertised technology bits 8:5 are read/write, reset from mode straps.
// - Partner bit 14 reads 1 once a code word was received.
// - Partner next page, fault, pause and technology bits are read-only copies.
// - Partner T4 bit 9 is read-only and never used locally.
// - Access by register index; unsupported indexes must not be used.
package phy_regs_pkg;
   localparam int IDX_W = 5;
   localparam int DATA_W = 16;
   localparam logic [4:0] IDX_BASIC_STATUS = 5'h01;
   localparam logic [4:0] IDX_ID_HIGH = 5'h02;
   localparam logic [4:0] IDX_ID_LOW = 5'h03;
   localparam logic [4:0] IDX_ADV = 5'h04;
   localparam logic [4:0] IDX_PARTNER = 5'h05;

   localparam int BS_EXT_STATUS = 8;
   localparam int BS_AN_DONE = 5;
   localparam int BS_RFAULT = 4;
   localparam int BS_AN_ABLE = 3;
   localparam int BS_LINK = 2;
   localparam int BS_JABBER = 1;
   localparam int BS_EXT_CAP = 0;
   // Ability bits 14..11 set, 15/10/9 clear, plus bits 8, 3 and 0.
   localparam logic [15:0] BS_FIXED = 16'h7909;

   localparam int ADV_PAUSE = 10;
   localparam int TECH_LSB = 5;
   localparam int SEL_W = 5;
   localparam logic [4:0] SELECTOR_8023 = 5'h01;
   // Writable advert bits: 15, 13, 11, 10, 8:0.
   localparam logic [15:0] ADV_WR_MASK = 16'hADFF;
   localparam logic [15:0] ADV_RESET = 16'h0001;

   localparam int PA_ACK = 14;
   // Partner bits copied from the received word: 15, 13, 10, 9, 8:0.
   localparam logic [15:0] PA_COPY_MASK = 16'hA7FF;
   localparam logic [15:0] PA_RESET = 16'h0001;

   localparam logic [3:0] TECH_10_ONLY = 4'h3;
   localparam logic [3:0] TECH_100_ONLY = 4'hC;
   localparam logic [3:0] TECH_ALL = 4'hF;
   // The pin synchroniser needs four edges, so the straps are taken on the fifth.
   localparam logic [2:0] STRAP_SETTLE = 3'h5;

   function automatic logic [3:0] tech_from_mode(input logic [1:0] mode);
      case (mode)
         2'h0: tech_from_mode = TECH_10_ONLY;
         2'h1: tech_from_mode = TECH_100_ONLY;
         default: tech_from_mode = TECH_ALL;
      endcase
   endfunction : tech_from_mode
endpackage : phy_regs_pkg

// ### rtl/pin_sync.sv
module pin_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_out
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] out_ff;
   logic [W-1:0] nxt_out;

   // A bit changes only when the second and third stages agree.
   always_comb
   begin
      nxt_out = (s2_ff & s3_ff) | (out_ff & (s2_ff | s3_ff));
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         out_ff <= '0;
      end
      else
      begin
         s1_ff <= pin_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         out_ff <= nxt_out;
      end
   end

   assign pin_out = out_ff;
endmodule : pin_sync

// ### rtl/phy_status_autoneg_ability_regs.sv
module phy_status_autoneg_ability_regs
   import phy_regs_pkg::*;
#(
   // Identity defaults below are arbitrary neutral values.
   parameter logic [15:0] ID_HIGH_DEFAULT = 16'h1234,
   parameter logic [5:0] ID_OUI_LOW_DEFAULT = 6'h05,
   parameter logic [5:0] MODEL_DEFAULT = 6'h11,
   parameter logic [3:0] REV_DEFAULT = 4'h1
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic pause_strap_pin,
   input wire logic [1:0] mode_strap_pins,
   input wire logic link_up_pin,
   input wire logic jabber_pin,
   input wire logic remote_fault_pin,
   input wire logic an_complete,
   input wire logic an_restart,
   input wire logic partner_word_valid,
   input wire logic [DATA_W-1:0] partner_word,
   input wire logic [IDX_W-1:0] reg_index,
   input wire logic reg_rd_en,
   input wire logic reg_wr_en,
   input wire logic [DATA_W-1:0] reg_wr_data,
   output logic [DATA_W-1:0] reg_rd_data,
   output logic reg_rd_valid,
   output logic reg_index_err,
   output logic [DATA_W-1:0] adv_word
);
   logic [5:0] synced;
   logic link_live;
   logic jabber_live;
   logic rfault_live;
   logic pause_strap;
   logic [1:0] mode_strap;

   pin_sync #(
      .W(6)
   ) u_pin_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .pin_in({mode_strap_pins, pause_strap_pin, remote_fault_pin, jabber_pin,
         link_up_pin}),
      .pin_out(synced)
   );

   assign link_live = synced[0];
   assign jabber_live = synced[1];
   assign rfault_live = synced[2];
   assign pause_strap = synced[3];
   assign mode_strap = synced[5:4];

   // Access decode.
   logic rd_status;
   logic wr_id_high;
   logic wr_id_low;
   logic wr_adv;
   logic idx_known;

   assign rd_status = reg_rd_en && (reg_index == IDX_BASIC_STATUS);
   assign wr_id_high = reg_wr_en && (reg_index == IDX_ID_HIGH);
   assign wr_id_low = reg_wr_en && (reg_index == IDX_ID_LOW);
   assign wr_adv = reg_wr_en && (reg_index == IDX_ADV);
   assign idx_known = (reg_index >= IDX_BASIC_STATUS) && (reg_index <= IDX_PARTNER);

   // Strap capture a few cycles after reset, once the synchroniser settled.
   logic [2:0] settle_ff;
   logic [2:0] nxt_settle;
   logic strap_load;

   assign strap_load = (settle_ff == STRAP_SETTLE - 3'h1);

   always_comb
   begin
      nxt_settle = settle_ff;
      if (settle_ff != STRAP_SETTLE)
      begin
         nxt_settle = settle_ff + 3'h1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         settle_ff <= '0;
      end
      else
      begin
         settle_ff <= nxt_settle;
      end
   end

   // Status flags.
   logic rfault_ff;
   logic jabber_ff;
   logic link_ff;
   logic an_done_ff;
   logic nxt_rfault;
   logic nxt_jabber;
   logic nxt_link;
   logic nxt_an_done;

   always_comb
   begin
      // A read returns the latched value, then the flag follows the live level.
      // A new event in the read cycle is kept, because the flag is loaded with the live level.
      if (rd_status)
      begin
         nxt_rfault = rfault_live;
         nxt_jabber = jabber_live;
         nxt_link = link_live;
      end
      else
      begin
         nxt_rfault = rfault_ff | rfault_live;
         nxt_jabber = jabber_ff | jabber_live;
         nxt_link = link_ff & link_live;
      end
      nxt_an_done = an_complete;
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         rfault_ff <= 1'b0;
         jabber_ff <= 1'b0;
         link_ff <= 1'b0;
         an_done_ff <= 1'b0;
      end
      else
      begin
         rfault_ff <= nxt_rfault;
         jabber_ff <= nxt_jabber;
         link_ff <= nxt_link;
         an_done_ff <= nxt_an_done;
      end
   end

   // Identifier, advertisement and partner words.
   logic [15:0] id_high_ff;
   logic [15:0] id_low_ff;
   logic [15:0] adv_ff;
   logic [15:0] partner_ff;
   logic [15:0] nxt_id_high;
   logic [15:0] nxt_id_low;
   logic [15:0] nxt_adv;
   logic [15:0] nxt_partner;

   always_comb
   begin
      nxt_id_high = wr_id_high ? reg_wr_data : id_high_ff;
      nxt_id_low = wr_id_low ? reg_wr_data : id_low_ff;
      nxt_adv = adv_ff;
      if (strap_load)
      begin
         nxt_adv[ADV_PAUSE] = pause_strap;
         nxt_adv[TECH_LSB +: 4] = tech_from_mode(mode_strap);
      end
      if (wr_adv)
      begin
         nxt_adv = (reg_wr_data & ADV_WR_MASK) | (nxt_adv & ~ADV_WR_MASK);
      end
      nxt_partner = partner_ff;
      if (an_restart)
      begin
         nxt_partner = PA_RESET;
      end
      else if (partner_word_valid)
      begin
         nxt_partner = partner_word & PA_COPY_MASK;
         nxt_partner[PA_ACK] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         id_high_ff <= ID_HIGH_DEFAULT;
         id_low_ff <= {ID_OUI_LOW_DEFAULT, MODEL_DEFAULT, REV_DEFAULT};
         adv_ff <= ADV_RESET;
         partner_ff <= PA_RESET;
      end
      else
      begin
         id_high_ff <= nxt_id_high;
         id_low_ff <= nxt_id_low;
         adv_ff <= nxt_adv;
         partner_ff <= nxt_partner;
      end
   end

   // Read port.
   logic [15:0] rd_data_ff;
   logic rd_valid_ff;
   logic err_ff;
   logic [15:0] nxt_rd_data;
   logic nxt_rd_valid;
   logic nxt_err;
   logic [15:0] status_word;

   always_comb
   begin
      status_word = BS_FIXED;
      status_word[BS_AN_DONE] = an_done_ff;
      status_word[BS_RFAULT] = rfault_ff;
      status_word[BS_LINK] = link_ff;
      status_word[BS_JABBER] = jabber_ff;
      case (reg_index)
         IDX_BASIC_STATUS: nxt_rd_data = status_word;
         IDX_ID_HIGH: nxt_rd_data = id_high_ff;
         IDX_ID_LOW: nxt_rd_data = id_low_ff;
         IDX_ADV: nxt_rd_data = adv_ff;
         IDX_PARTNER: nxt_rd_data = partner_ff;
         default: nxt_rd_data = '0;
      endcase
      if (!reg_rd_en)
      begin
         nxt_rd_data = rd_data_ff;
      end
      nxt_rd_valid = reg_rd_en;
      nxt_err = (reg_rd_en || reg_wr_en) && !idx_known;
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         rd_data_ff <= '0;
         rd_valid_ff <= 1'b0;
         err_ff <= 1'b0;
      end
      else
      begin
         rd_data_ff <= nxt_rd_data;
         rd_valid_ff <= nxt_rd_valid;
         err_ff <= nxt_err;
      end
   end

   assign reg_rd_data = rd_data_ff;
   assign reg_rd_valid = rd_valid_ff;
   assign reg_index_err = err_ff;
   assign adv_word = adv_ff;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence s_status_read;
      reg_rd_en && reg_index == IDX_BASIC_STATUS;
   endsequence

   property p_tx_abilities;
      s_status_read |=> reg_rd_valid && reg_rd_data[14:13] == 2'h3;
   endproperty
   a_tx_abilities: assert property (p_tx_abilities) else $error("TX ability bits not set");

   property p_ten_abilities;
      s_status_read |=> reg_rd_data[12:11] == 2'h3;
   endproperty
   a_ten_abilities: assert property (p_ten_abilities) else $error("10M ability bits clear");

   property p_no_t4_t2;
      s_status_read |=> reg_rd_data[15] == 1'b0 && reg_rd_data[10:9] == 2'h0;
   endproperty
   a_no_t4_t2: assert property (p_no_t4_t2) else $error("T4 or T2 bit reads 1");

   property p_ext_bits;
      s_status_read |=> reg_rd_data[BS_EXT_STATUS] && reg_rd_data[BS_AN_ABLE]
         && reg_rd_data[BS_EXT_CAP];
   endproperty
   a_ext_bits: assert property (p_ext_bits) else $error("Capability bits wrong");

   property p_an_done;
      s_status_read |=> reg_rd_data[BS_AN_DONE] == $past(an_complete, 2);
   endproperty
   a_an_done: assert property (p_an_done) else $error("Negotiation done bit wrong");

   property p_fault_holds;
      rfault_ff && !rd_status |=> rfault_ff [*1];
   endproperty
   a_fault_holds: assert property (p_fault_holds) else $error("Remote fault not held");

   property p_link_low;
      !link_live |=> !link_ff;
   endproperty
   a_link_low: assert property (p_link_low) else $error("Link drop not latched");

   property p_jabber_read;
      jabber_ff && !jabber_live ##0 s_status_read |=> reg_rd_data[BS_JABBER] && !jabber_ff;
   endproperty
   a_jabber_read: assert property (p_jabber_read) else $error("Jabber read clear wrong");

   sequence s_id_write_read;
      wr_id_high && !reg_rd_en ##1 !reg_wr_en && !reg_rd_en
         ##1 reg_rd_en && reg_index == IDX_ID_HIGH && !reg_wr_en;
   endsequence

   property p_id_rw;
      logic [15:0] d;
      (s_id_write_read, d = $past(reg_wr_data, 2)) |=> reg_rd_data == d;
   endproperty
   a_id_rw: assert property (p_id_rw) else $error("Identifier readback wrong");

   property p_adv_write;
      wr_adv |=> (adv_ff & ADV_WR_MASK) == ($past(reg_wr_data) & ADV_WR_MASK)
         && (adv_ff & ~ADV_WR_MASK) == 16'h0000;
   endproperty
   a_adv_write: assert property (p_adv_write) else $error("Advert write wrong");

   property p_strap;
      strap_load && !wr_adv |=> adv_word[ADV_PAUSE] == $past(pause_strap)
         && adv_word[TECH_LSB +: 4] == tech_from_mode($past(mode_strap));
   endproperty
   a_strap: assert property (p_strap) else $error("Strap defaults not loaded");

   property p_partner;
      partner_word_valid && !an_restart |=> partner_ff[PA_ACK]
         && (partner_ff & PA_COPY_MASK) == ($past(partner_word) & PA_COPY_MASK);
   endproperty
   a_partner: assert property (p_partner) else $error("Partner word not copied");

   property p_unmapped;
      reg_rd_en && !idx_known |=> reg_rd_data == 16'h0000 && reg_index_err;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("Unmapped read not flagged");
endmodule : phy_status_autoneg_ability_regs

// ### tb/mgmt_station.sv
module mgmt_station
   import phy_regs_pkg::*;
(
   input wire logic ref_clk,
   output logic [IDX_W-1:0] reg_index,
   output logic reg_rd_en,
   output logic reg_wr_en,
   output logic [DATA_W-1:0] reg_wr_data,
   input wire logic [DATA_W-1:0] reg_rd_data,
   input wire logic reg_rd_valid,
   input wire logic reg_index_err
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      reg_index = '0;
      reg_rd_en = 1'b0;
      reg_wr_en = 1'b0;
      reg_wr_data = '0;
   end

   // Released lines carry the inverse of the last value, so a stale index never looks live.
   task automatic wr(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] data);
      @(posedge ref_clk);
      reg_index <= idx;
      reg_wr_data <= data;
      reg_wr_en <= 1'b1;
      @(posedge ref_clk);
      reg_wr_en <= 1'b0;
      reg_index <= ~idx;
      reg_wr_data <= ~data;
   endtask : wr

   task automatic rd(input logic [IDX_W-1:0] idx, output logic [DATA_W-1:0] data,
                     output logic err);
      @(posedge ref_clk);
      reg_index <= idx;
      reg_rd_en <= 1'b1;
      @(posedge ref_clk);
      reg_rd_en <= 1'b0;
      reg_index <= ~idx;
      // The answer launched at the request edge is taken at the following edge.
      @(posedge ref_clk);
      data = (reg_rd_valid === 1'b1) ? reg_rd_data : 'x;
      err = reg_index_err;
   endtask : rd
endmodule : mgmt_station

// ### tb/tb.sv
module tb
   import phy_regs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic ref_clk, sys_rst, pause_strap_pin, an_complete, an_restart, partner_word_valid;
   logic [1:0] mode_strap_pins;
   logic [2:0] ev;
   logic [DATA_W-1:0] partner_word, reg_wr_data, reg_rd_data, adv_word, got, exp_v;
   logic [IDX_W-1:0] reg_index;
   logic reg_rd_en, reg_wr_en, reg_rd_valid, reg_index_err, err;
   logic [3:0] tech;
   int error_cnt, n_compared, cyc;
   logic [15:0] flip [3] = '{16'h0002, 16'h0010, 16'h0004};
   logic [4:0] bad_idx [3] = '{5'h00, 5'h06, 5'h1F};

   phy_status_autoneg_ability_regs uut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .pause_strap_pin(pause_strap_pin),
      .mode_strap_pins(mode_strap_pins), .link_up_pin(~ev[2]), .jabber_pin(ev[0]),
      .remote_fault_pin(ev[1]), .an_complete(an_complete), .an_restart(an_restart),
      .partner_word_valid(partner_word_valid), .partner_word(partner_word),
      .reg_index(reg_index), .reg_rd_en(reg_rd_en), .reg_wr_en(reg_wr_en),
      .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
      .reg_index_err(reg_index_err), .adv_word(adv_word));

   mgmt_station mgmt (
      .ref_clk(ref_clk), .reg_index(reg_index), .reg_rd_en(reg_rd_en),
      .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
      .reg_rd_valid(reg_rd_valid), .reg_index_err(reg_index_err));

   always #50 ref_clk = ~ref_clk;

   task automatic final_report();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report

   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         error_cnt++;
         final_report();
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic rdc(input logic [4:0] idx, input logic [15:0] exp, input logic exp_err);
      mgmt.rd(idx, got, err);
      chk("read data", exp, got);
      chk("index error", {15'h0000, exp_err}, {15'h0000, err});
   endtask : rdc

   task automatic do_reset();
      sys_rst <= 1'b1;
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (8) @(posedge ref_clk);
   endtask : do_reset

   initial
   begin
      ref_clk = 1'b0;
      sys_rst = 1'b1;
      pause_strap_pin = 1'b0;
      mode_strap_pins = 2'h0;
      ev = 3'h0;
      an_complete = 1'b0;
      an_restart = 1'b0;
      partner_word_valid = 1'b0;
      partner_word = 16'h0000;
      error_cnt = 0;
      n_compared = 0;
      cyc = 0;
      for (int m = 0; m < 4; m++)
      begin
         mode_strap_pins <= m[1:0];
         pause_strap_pin <= m[0];
         do_reset();
         tech = (m == 0) ? 4'h3 : (m == 1) ? 4'hC : 4'hF;
         exp_v = {5'h00, m[0], 1'b0, tech, 5'h01};
         chk("adv_word", exp_v, adv_word);
         rdc(IDX_ADV, exp_v, 1'b0);
      end
      rdc(IDX_ID_HIGH, 16'h1234, 1'b0);
      rdc(IDX_ID_LOW, 16'h1511, 1'b0);
      rdc(IDX_PARTNER, 16'h0001, 1'b0);
      mgmt.wr(IDX_ID_HIGH, 16'hABCD);
      rdc(IDX_ID_HIGH, 16'hABCD, 1'b0);
      mgmt.wr(IDX_ID_LOW, 16'h5A5A);
      rdc(IDX_ID_LOW, 16'h5A5A, 1'b0);
      mgmt.wr(IDX_ADV, 16'hFFFF);
      rdc(IDX_ADV, 16'hADFF, 1'b0);
      mgmt.wr(IDX_ADV, 16'h0000);
      rdc(IDX_ADV, 16'h0000, 1'b0);
      mgmt.wr(IDX_BASIC_STATUS, 16'hFFFF);
      mgmt.wr(IDX_PARTNER, 16'h0000);
      mgmt.rd(IDX_BASIC_STATUS, got, err);
      rdc(IDX_BASIC_STATUS, 16'h790D, 1'b0);
      rdc(IDX_PARTNER, 16'h0001, 1'b0);
      @(posedge ref_clk);
      partner_word_valid <= 1'b1;
      partner_word <= 16'hFFFF;
      @(posedge ref_clk);
      partner_word_valid <= 1'b0;
      partner_word <= 16'h0000;
      rdc(IDX_PARTNER, 16'hE7FF, 1'b0);
      an_restart <= 1'b1;
      @(posedge ref_clk);
      an_restart <= 1'b0;
      rdc(IDX_PARTNER, 16'h0001, 1'b0);
      an_complete <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rdc(IDX_BASIC_STATUS, 16'h792D, 1'b0);
      // Each event is short-lived, so only the latch can still report it at the read.
      for (int i = 0; i < 3; i++)
      begin
         ev <= 3'(1 << i);
         repeat (6) @(posedge ref_clk);
         ev <= 3'h0;
         repeat (8) @(posedge ref_clk);
         rdc(IDX_BASIC_STATUS, 16'h792D ^ flip[i], 1'b0);
         rdc(IDX_BASIC_STATUS, 16'h792D, 1'b0);
      end
      for (int k = 0; k < 3; k++)
      begin
         mgmt.wr(bad_idx[k], 16'hFFFF);
         rdc(bad_idx[k], 16'h0000, 1'b1);
      end
      rdc(IDX_ADV, 16'h0000, 1'b0);
      final_report();
   end
endmodule : tb
